// File: dv/transponder_teach_in_control_tb.sv
`timescale 1ns/10ps
module transponder_teach_in_control_tb;
   // One cycle per tick keeps the 60 s teach inside the run budget
   localparam int T = 1;
   logic                       core_clk;
   logic                       sys_rst;
   logic                       supply_on;
   logic                       tag_present;
   logic [tti_pkg::CODE_W-1:0] tag_code;
   logic                       safety_output_a;
   logic                       safety_output_b;
   logic                       diag_out;
   logic                       led_green;
   logic                       led_red;
   logic                       led_yellow;
   logic                       off_watch;
   int                         n_fail;
   int                         comparisons;
   int                         w;
   int                         n;
   time                        t0;
   ////////////////////////////////////////////////////////////////////////////
   tti_teach_ctrl #(.TICK_CYCLES(T)) dut (
      .core_clk        (core_clk),
      .sys_rst         (sys_rst),
      .supply_on       (supply_on),
      .tag_present     (tag_present),
      .tag_code        (tag_code),
      .safety_output_a (safety_output_a),
      .safety_output_b (safety_output_b),
      .diag_out        (diag_out),
      .led_green       (led_green),
      .led_red         (led_red),
      .led_yellow      (led_yellow)
   );
   tti_actuator_model act (
      .core_clk    (core_clk),
      .supply_on   (supply_on),
      .tag_present (tag_present),
      .tag_code    (tag_code)
   );
   always #5 core_clk = ~core_clk;
   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH %s expected %0d seen %0d", what, exp, got);
      end
   endtask : check
   task automatic report_and_stop();
      if (n_fail == 0 && comparisons > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : report_and_stop
   // Outputs must stay off during self-test, teach-in and faults
   always @(posedge core_clk) begin
      #1;
      if (off_watch && {safety_output_a, safety_output_b, diag_out} !== 3'b000) begin
         check("outputs off", 0, {safety_output_a, safety_output_b, diag_out});
      end
   end
   function automatic logic sig(input int sel);
      case (sel)
         0: return led_green;
         1: return led_red;
         default: return safety_output_a;
      endcase
   endfunction : sig
   // Bounded wait; running out ends the run as a failure
   task automatic wait_for(input int sel, input logic v, input int bound);
      for (int i = 0; i < bound; i++) begin
         if (sig(sel) === v) return;
         @(posedge core_clk);
         #1;
      end
      check("wait bound", 1, 0);
      report_and_stop();
   endtask : wait_for
   // Length of the next full green pulse, capped so steady light ends it
   task automatic high_time(output int len);
      wait_for(0, 1'b0, 3000 * T);
      wait_for(0, 1'b1, 3000 * T);
      len = 1;
      while (len < 3000 * T) begin
         @(posedge core_clk);
         #1;
         if (led_green !== 1'b1) break;
         len++;
      end
   endtask : high_time
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_ready();
      high_time(w);
      check("ready blink half period", 125 * T, w);
   endtask : t_ready
   // Tag leaves during teach-in well before the 60 s are up
   task automatic t_cancel();
      act.place(16'h2222);
      repeat (1000 * T) @(negedge core_clk);
      act.remove();
      wait_for(1, 1'b1, 20);
   endtask : t_cancel
   // Guard open then closed, each a bit over 2 s; teach-in follows at once
   task automatic t_clear_teach();
      int run;
      repeat (2100 * T) @(negedge core_clk);
      act.place(16'h1111);
      wait_for(1, 1'b0, 2300 * T);
      t0 = $time;
      high_time(w);
      check("teach blink half period", 500 * T, w);
      run = 0;
      for (int i = 0; i < 62000 * T && run < 1100 * T; i++) begin
         @(posedge core_clk);
         #1;
         run = (led_green === 1'b0) ? run + 1 : 0;
      end
      // Last 1 Hz half period is dark, so the lamp goes dark for good at 59.5 s
      n = int'(($time - t0) / 10) - run;
      check("teach length", 1, n > 59450 * T && n < 59550 * T);
   endtask : t_clear_teach
   // Activation by power cycle, then status count and normal mode
   task automatic t_activate();
      act.remove();
      act.power_cycle(3010 * T);
      n = 0;
      high_time(w);
      while (w < 600 * T && n < 8) begin
         check("status blink width", 250 * T, w);
         n++;
         high_time(w);
      end
      check("status blink count", 3, n);
      off_watch = 1'b0;
      act.place(16'h1111);
      wait_for(2, 1'b1, 20);
      check("normal outputs", 4'hF, {safety_output_a, safety_output_b, diag_out, led_yellow});
   endtask : t_activate
   // Long presence leaves quietly; presence well under half a second faults
   task automatic t_short();
      repeat (600 * T) @(negedge core_clk);
      act.remove();
      wait_for(2, 1'b0, 20);
      check("red after long presence", 0, led_red);
      act.place(16'h1111);
      wait_for(2, 1'b1, 20);
      repeat (100 * T) @(negedge core_clk);
      act.remove();
      wait_for(1, 1'b1, 20);
   endtask : t_short
   ////////////////////////////////////////////////////////////////////////////
   // Factory reset, supply on, then the scenarios in order
   initial begin
      core_clk    = 1'b0;
      sys_rst     = 1'b1;
      off_watch   = 1'b1;
      n_fail      = 0;
      comparisons = 0;
      repeat (6) @(posedge core_clk);
      @(negedge core_clk);
      sys_rst = 1'b0;
      act.power(1'b1);
      t_ready();
      t_cancel();
      t_clear_teach();
      t_activate();
      t_short();
      report_and_stop();
   end
endmodule : transponder_teach_in_control_tb

// File: dv/tti_actuator_model.sv
`timescale 1ns/10ps
// Actuator tag and machine supply seen from outside the switch
module tti_actuator_model (
   input  wire logic                       core_clk,
   output logic                            supply_on,
   output logic                            tag_present,
   output logic [tti_pkg::CODE_W-1:0]      tag_code
);
   // Unpowered, no tag, at time zero
   initial begin
      supply_on   = 1'b0;
      tag_present = 1'b0;
      tag_code    = 16'h0000;
   end
   ////////////////////////////////////////////////////////////////////////////
   // Tag moves in front of the read head, code steady while there
   task automatic place(input logic [tti_pkg::CODE_W-1:0] code);
      @(negedge core_clk);
      tag_code    = code;
      tag_present = 1'b1;
   endtask : place
   // Code line is not held once the tag leaves, so it toggles
   task automatic remove();
      @(negedge core_clk);
      tag_present = 1'b0;
      tag_code    = ~tag_code;
   endtask : remove
   task automatic power(input logic on);
      @(negedge core_clk);
      supply_on = on;
   endtask : power
   // Operator removes supply for the given cycles, then restores it
   task automatic power_cycle(input int off_cycles);
      power(1'b0);
      repeat (off_cycles) @(negedge core_clk);
      power(1'b1);
   endtask : power_cycle
endmodule : tti_actuator_model

// File: rtl/tti_hist_if.sv
`timescale 1ns/10ps
// Write port and stored codes of the learned-code history
interface tti_hist_if;
   logic                                          wr_en;
   logic [tti_pkg::IDX_W-1:0]                     wr_idx;
   logic [tti_pkg::CODE_W-1:0]                    wr_data;
   logic [tti_pkg::HIST_N-1:0][tti_pkg::CODE_W-1:0] entries;

   modport ctl (output wr_en, output wr_idx, output wr_data, input entries);
   modport mem (input wr_en, input wr_idx, input wr_data, output entries);
endinterface : tti_hist_if

// File: rtl/tti_hist_mem.sv
`timescale 1ns/10ps
// Learned-code history, every entry visible from a register
module tti_hist_mem (
   input  wire logic core_clk,
   input  wire logic sys_rst,
   tti_hist_if.mem   hist
);
   tti_pkg::tti_mem_type q;
   tti_pkg::tti_mem_type d;

   // One entry written per completed teach-in
   always_comb begin
      d = q;
      if (hist.wr_en) begin
         d.ent[hist.wr_idx] = hist.wr_data;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign hist.entries = q.ent;
endmodule : tti_hist_mem

// File: rtl/tti_pkg.sv
package tti_pkg;

   // Clock and millisecond tick
   localparam int unsigned CLK_HZ      = 100_000_000;
   localparam int unsigned TICK_MS     = 1;
   localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;

   // Code history geometry
   localparam int          CODE_W   = 16;
   localparam int          HIST_N   = 8;
   localparam int          IDX_W    = 3;
   localparam int          CNT_W    = 4;
   localparam int          TMR_W    = 16;
   localparam logic [3:0]  HIST_MAX = 4'h8;
   localparam logic [3:0]  FULL_BLINK_CNT = 4'h5;

   // Times in milliseconds
   localparam logic [15:0] SELFTEST_MS  = 16'h0064;
   localparam logic [15:0] TEACH_MS     = 16'hEA60;
   localparam logic [15:0] PWR_OFF_MS   = 16'h0BB8;
   localparam logic [15:0] MIN_PRES_MS  = 16'h01F4;
   localparam logic [15:0] CLR_MS       = 16'h07D0;
   localparam logic [15:0] STAT_HOLD_MS = 16'h03E8;
   localparam logic [15:0] STAT_HALF_MS = 16'h00FA;

   // Blink rates, half periods derived in milliseconds
   localparam int unsigned READY_HZ      = 4;
   localparam int unsigned TEACH_HZ      = 1;
   localparam logic [15:0] READY_HALF_MS = 16'(1000 / (2 * READY_HZ));
   localparam logic [15:0] TEACH_HALF_MS = 16'(1000 / (2 * TEACH_HZ));

   // Green blink counts
   localparam logic [1:0]  BLINK_MAX     = 2'h3;
   localparam logic [1:0]  ERR_OVER      = 2'h1;
   localparam logic [1:0]  ERR_OLD       = 2'h2;
   localparam logic [1:0]  ERR_CANCEL    = 2'h3;

   typedef enum logic [7:0] {
      ST_OFF    = 8'h01,
      ST_SELF   = 8'h02,
      ST_STAT   = 8'h04,
      ST_READY  = 8'h08,
      ST_TEACH  = 8'h10,
      ST_TAUGHT = 8'h20,
      ST_NORM   = 8'h40,
      ST_FAULT  = 8'h80
   } tti_state_type;

   typedef struct packed {
      logic [HIST_N-1:0][CODE_W-1:0] ent;
   } tti_mem_type;

endpackage : tti_pkg

// File: rtl/tti_teach_ctrl.sv
`timescale 1ns/10ps
// Start-up, teach-in and fault control of the transponder switch
module tti_teach_ctrl #(
   parameter int unsigned TICK_CYCLES = tti_pkg::TICK_CYCLES
) (
   input  wire logic                       core_clk,
   input  wire logic                       sys_rst,
   input  wire logic                       supply_on,
   input  wire logic                       tag_present,
   input  wire logic [tti_pkg::CODE_W-1:0] tag_code,
   output logic                            safety_output_a,
   output logic                            safety_output_b,
   output logic                            diag_out,
   output logic                            led_green,
   output logic                            led_red,
   output logic                            led_yellow
);

   typedef struct packed {
      tti_pkg::tti_state_type     state;
      logic                       sup_s1;
      logic                       sup_s2;
      logic                       tag_s1;
      logic                       tag_s2;
      logic                       tag_s3;
      logic [tti_pkg::CODE_W-1:0] code_s1;
      logic [tti_pkg::CODE_W-1:0] code_s2;
      logic [tti_pkg::TMR_W-1:0]  tmr;
      logic [tti_pkg::TMR_W-1:0]  off_ms;
      logic [tti_pkg::TMR_W-1:0]  pres_ms;
      logic [tti_pkg::TMR_W-1:0]  blk_ms;
      logic [1:0]                 blinks;
      logic                       clr_phase;
      logic [tti_pkg::CNT_W-1:0]  count;
      logic [tti_pkg::CODE_W-1:0] active;
      logic                       act_valid;
      logic [tti_pkg::CODE_W-1:0] blocked;
      logic                       blk_valid;
      logic [tti_pkg::CODE_W-1:0] pending;
      logic                       pend_valid;
      logic                       teach_bad;
      logic                       hist_we;
      logic [tti_pkg::IDX_W-1:0]  hist_idx;
      logic                       out_a;
      logic                       out_b;
      logic                       diag;
      logic                       led_g;
      logic                       led_r;
      logic                       led_y;
   } tti_ctrl_type;

   localparam tti_ctrl_type RST = '{state: tti_pkg::ST_OFF, default: '0};

   tti_ctrl_type               q;
   tti_ctrl_type               d;
   logic                       tick;
   logic [tti_pkg::HIST_N-1:0] hit;
   logic [tti_pkg::TMR_W-1:0]  half_ms;
   logic                       blink_run;
   logic                       code_ok;

   tti_hist_if hist ();

   ////////////////////////////////////////////////////////////////////////////
   // Sub-blocks

   tti_tick_gen #(
      .TICK_CYCLES (TICK_CYCLES)
   ) u_tick (
      .core_clk (core_clk),
      .sys_rst  (sys_rst),
      .tick     (tick)
   );

   tti_hist_mem u_mem (
      .core_clk (core_clk),
      .sys_rst  (sys_rst),
      .hist     (hist.mem)
   );

   // History write follows the completion cycle by one clock
   assign hist.wr_en   = q.hist_we;
   assign hist.wr_idx  = q.hist_idx;
   assign hist.wr_data = q.pending;

   // Compare the presented code against every learned entry
   for (genvar i = 0; i < tti_pkg::HIST_N; i++) begin : g_hit
      assign hit[i] = (4'(i) < q.count) && (hist.entries[i] == q.code_s2);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Next-state logic

   // Blink half period and whether it runs, per state
   always_comb begin
      half_ms   = tti_pkg::STAT_HALF_MS;
      blink_run = 1'b0;
      case (q.state)
         tti_pkg::ST_READY: begin
            half_ms   = tti_pkg::READY_HALF_MS;
            blink_run = (q.count != tti_pkg::HIST_MAX);
         end
         tti_pkg::ST_TEACH: begin
            half_ms   = tti_pkg::TEACH_HALF_MS;
            blink_run = 1'b1;
         end
         tti_pkg::ST_STAT:  blink_run = (q.blinks != 2'h0);
         tti_pkg::ST_FAULT: blink_run = (q.blinks != 2'h0);
         default:           blink_run = 1'b0;
      endcase
   end

   assign code_ok = q.act_valid && q.tag_s2 && (q.code_s2 == q.active);

   always_comb begin
      d         = q;
      d.hist_we = 1'b0;
      // Two flip-flops on every pin, a third on the tag for its falling edge
      d.sup_s1  = supply_on;
      d.sup_s2  = q.sup_s1;
      d.tag_s1  = tag_present;
      d.tag_s2  = q.tag_s1;
      d.tag_s3  = q.tag_s2;
      d.code_s1 = tag_code;
      d.code_s2 = q.code_s1;

      // Millisecond counters, all saturating
      if (!q.tag_s2) begin
         d.pres_ms = '0;
      end else if (tick && q.pres_ms != tti_pkg::MIN_PRES_MS) begin
         d.pres_ms = q.pres_ms + 16'h0001;
      end
      if (tick && q.tmr != 16'hFFFF) begin
         d.tmr = q.tmr + 16'h0001;
      end

      // Blink generator; a falling edge ends one counted blink
      if (tick && blink_run) begin
         if (q.blk_ms == half_ms - 16'h0001) begin
            d.blk_ms = '0;
            d.led_g  = !q.led_g;
            if (q.led_g && q.state inside {tti_pkg::ST_STAT, tti_pkg::ST_FAULT}) begin
               d.blinks = q.blinks - 2'h1;
               if (q.blinks == 2'h1 && q.state == tti_pkg::ST_STAT) begin
                  d.tmr = '0;
               end
            end
         end else begin
            d.blk_ms = q.blk_ms + 16'h0001;
         end
      end

      case (q.state)
         tti_pkg::ST_OFF: begin
            if (!q.sup_s2) begin
               if (tick && q.off_ms != tti_pkg::PWR_OFF_MS) begin
                  d.off_ms = q.off_ms + 16'h0001;
               end
            end else begin
               // Activation needs a long enough supply gap
               if (q.off_ms == tti_pkg::PWR_OFF_MS && q.pend_valid) begin
                  d.blocked    = q.active;
                  d.blk_valid  = q.act_valid;
                  d.active     = q.pending;
                  d.act_valid  = 1'b1;
                  d.pend_valid = 1'b0;
               end
               d.off_ms = '0;
               d.state  = tti_pkg::ST_SELF;
            end
         end
         tti_pkg::ST_SELF: begin
            if (q.tmr >= tti_pkg::SELFTEST_MS) begin
               if (q.teach_bad) begin
                  d.teach_bad = 1'b0;
                  d.blinks    = 2'h0;
                  d.clr_phase = 1'b0;
                  d.state     = tti_pkg::ST_FAULT;
               end else if (q.count != 4'h0 && q.count != tti_pkg::HIST_MAX) begin
                  d.blinks = (q.count <= tti_pkg::FULL_BLINK_CNT) ? tti_pkg::BLINK_MAX
                           : 2'(tti_pkg::HIST_MAX - q.count);
                  d.state  = tti_pkg::ST_STAT;
               end else begin
                  d.state = tti_pkg::ST_READY;
               end
            end
         end
         tti_pkg::ST_STAT: begin
            // Last blink keeps its dark half, else one blink would look like steady light
            if (q.blinks == 2'h0 && tick && q.tmr == tti_pkg::STAT_HALF_MS - 16'h0001) begin
               d.led_g = 1'b1;
            end
            if (q.blinks == 2'h0 && q.tmr >= tti_pkg::STAT_HALF_MS + tti_pkg::STAT_HOLD_MS) begin
               d.state = tti_pkg::ST_READY;
            end
         end
         tti_pkg::ST_READY: begin
            if (q.tag_s2) begin
               if (code_ok) begin
                  d.state = tti_pkg::ST_NORM;
               end else if (q.blk_valid && q.code_s2 == q.blocked) begin
                  d.state = tti_pkg::ST_READY;
               end else if (q.count == tti_pkg::HIST_MAX) begin
                  d.blinks    = tti_pkg::ERR_OVER;
                  d.clr_phase = 1'b0;
                  d.state     = tti_pkg::ST_FAULT;
               end else if (|hit) begin
                  d.blinks    = tti_pkg::ERR_OLD;
                  d.clr_phase = 1'b0;
                  d.state     = tti_pkg::ST_FAULT;
               end else begin
                  d.state = tti_pkg::ST_TEACH;
               end
            end
         end
         tti_pkg::ST_TEACH: begin
            if (!q.tag_s2) begin
               d.blinks    = tti_pkg::ERR_CANCEL;
               d.clr_phase = 1'b0;
               d.state     = tti_pkg::ST_FAULT;
            end else if (tick && q.tmr == tti_pkg::TEACH_MS - 16'h0001) begin
               d.pending    = q.code_s2;
               d.pend_valid = 1'b1;
               d.hist_we    = 1'b1;
               d.hist_idx   = q.count[tti_pkg::IDX_W-1:0];
               d.count      = q.count + 4'h1;
               d.state      = tti_pkg::ST_TAUGHT;
            end
         end
         tti_pkg::ST_TAUGHT: d.state = tti_pkg::ST_TAUGHT;
         tti_pkg::ST_NORM: begin
            // A touch shorter than the minimum is treated as tampering
            if (q.tag_s3 && !q.tag_s2 && q.pres_ms != tti_pkg::MIN_PRES_MS) begin
               d.blinks    = 2'h0;
               d.clr_phase = 1'b0;
               d.state     = tti_pkg::ST_FAULT;
            end
         end
         tti_pkg::ST_FAULT: begin
            // Open for the clear time CLR_MS, then closed for the clear time CLR_MS
            if (q.tag_s2 != q.clr_phase) begin
               d.tmr = '0;
            end else if (q.tmr >= tti_pkg::CLR_MS) begin
               d.tmr = '0;
               if (q.clr_phase) begin
                  d.state = tti_pkg::ST_READY;
               end else begin
                  d.clr_phase = 1'b1;
               end
            end
         end
         default: d.state = tti_pkg::ST_OFF;
      endcase

      // Supply loss wins over the next state; an open teach-in is marked bad, even one that completes in that same cycle
      if (!q.sup_s2 && q.state != tti_pkg::ST_OFF) begin
         d.teach_bad = q.teach_bad || (q.state == tti_pkg::ST_TEACH);
         d.off_ms    = '0;
         d.state     = tti_pkg::ST_OFF;
      end

      // Timers restart and blinking starts lit on every state change
      if (d.state != q.state) begin
         d.tmr    = '0;
         d.blk_ms = '0;
         d.led_g  = (d.state inside {tti_pkg::ST_STAT, tti_pkg::ST_TEACH,
                                     tti_pkg::ST_NORM})
                 || (d.state == tti_pkg::ST_READY && d.count != tti_pkg::HIST_MAX)
                 || (d.state == tti_pkg::ST_FAULT && d.blinks != 2'h0);
      end

      // Outputs only in normal mode with the active code in place
      d.out_a = (d.state == tti_pkg::ST_NORM) && code_ok;
      d.out_b = (d.state == tti_pkg::ST_NORM) && code_ok;
      d.diag  = (d.state == tti_pkg::ST_NORM) && code_ok;
      d.led_y = (d.state == tti_pkg::ST_NORM) && code_ok;
      d.led_r = (d.state == tti_pkg::ST_FAULT);
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         q <= RST;
      end else begin
         q <= d;
      end
   end

   assign safety_output_a = q.out_a;
   assign safety_output_b = q.out_b;
   assign diag_out        = q.diag;
   assign led_green       = q.led_g;
   assign led_red         = q.led_r;
   assign led_yellow      = q.led_y;

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   a_selftest_outputs_off: assert property (
      q.state == tti_pkg::ST_SELF |-> !safety_output_a && !safety_output_b)
      else $error("safety output on during self-test");

   a_teach_outputs_low: assert property (
      q.state == tti_pkg::ST_TEACH |-> !safety_output_a && !safety_output_b && !diag_out)
      else $error("output high during teach-in");

   a_ready_blink_toggle: assert property (
      q.state == tti_pkg::ST_READY && q.count != tti_pkg::HIST_MAX && tick && q.tag_s2 == 1'b0
      && q.sup_s2 && q.blk_ms == tti_pkg::READY_HALF_MS - 16'h0001 |=> $changed(led_green))
      else $error("ready blink did not toggle");

   a_teach_done_dark: assert property (
      q.state == tti_pkg::ST_TEACH && q.sup_s2 && q.tag_s2 && tick
      && q.tmr == tti_pkg::TEACH_MS - 16'h0001
      |=> q.state == tti_pkg::ST_TAUGHT && !led_green && hist.wr_en)
      else $error("teach-in completion wrong");

   a_cancel_to_fault: assert property (
      q.state == tti_pkg::ST_TEACH && q.sup_s2 && !q.tag_s2
      |=> q.state == tti_pkg::ST_FAULT && led_red && q.blinks == tti_pkg::ERR_CANCEL)
      else $error("cancelled teach-in not faulted");

   a_outputs_need_code: assert property (
      safety_output_a |-> $past(q.act_valid && q.tag_s2 && q.code_s2 == q.active)
      && safety_output_b == safety_output_a)
      else $error("outputs on without active code");

   a_count_limit: assert property (
      hist.wr_en |-> q.count <= tti_pkg::HIST_MAX && q.count != 4'h0)
      else $error("teach-in count exceeded");

   a_teach_fresh_code: assert property (
      q.state == tti_pkg::ST_READY && q.sup_s2 && d.state == tti_pkg::ST_TEACH
      |-> hit == '0 && !(q.blk_valid && q.code_s2 == q.blocked))
      else $error("teach-in started for a known code");

   a_activate_swap: assert property (
      q.state == tti_pkg::ST_OFF && q.sup_s2 && q.pend_valid
      && q.off_ms == tti_pkg::PWR_OFF_MS
      |=> q.active == $past(q.pending) && q.blocked == $past(q.active) && !q.pend_valid)
      else $error("code activation wrong");

   a_short_presence: assert property (
      q.state == tti_pkg::ST_NORM && q.sup_s2 && q.tag_s3 && !q.tag_s2
      && q.pres_ms < tti_pkg::MIN_PRES_MS |=> q.state == tti_pkg::ST_FAULT)
      else $error("short presence not faulted");

   a_ninth_rejected: assert property (
      q.state == tti_pkg::ST_READY && q.sup_s2 && q.count == tti_pkg::HIST_MAX
      && q.tag_s2 && !code_ok && !(q.blk_valid && q.code_s2 == q.blocked)
      |=> q.state == tti_pkg::ST_FAULT && q.blinks == tti_pkg::ERR_OVER)
      else $error("ninth teach-in not rejected");

   c_normal_entry: cover property (q.state == tti_pkg::ST_READY ##1 q.state == tti_pkg::ST_NORM);
   c_teach_done:   cover property (q.state == tti_pkg::ST_TEACH ##1 q.state == tti_pkg::ST_TAUGHT);
   c_activation:   cover property (q.pend_valid ##1 !q.pend_valid && q.act_valid);
   c_fault_clear:  cover property (q.state == tti_pkg::ST_FAULT ##1 q.state == tti_pkg::ST_READY);

endmodule : tti_teach_ctrl

// File: rtl/tti_tick_gen.sv
`timescale 1ns/10ps
// Millisecond enable pulse for all blink and timeout counters
module tti_tick_gen #(
   parameter int unsigned TICK_CYCLES = tti_pkg::TICK_CYCLES
) (
   input  wire logic core_clk,
   input  wire logic sys_rst,
   output logic      tick
);
   localparam int CW = $clog2(TICK_CYCLES + 1);
   localparam logic [CW-1:0] LAST = CW'(TICK_CYCLES - 1);

   typedef struct packed {
      logic [CW-1:0] cnt;
      logic          tick;
   } tti_tick_type;

   tti_tick_type q;
   tti_tick_type d;

   // Free divider, restarts with the reset
   always_comb begin
      d      = q;
      d.tick = 1'b0;
      if (q.cnt == LAST) begin
         d.cnt  = '0;
         d.tick = 1'b1;
      end else begin
         d.cnt = q.cnt + CW'(1);
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign tick = q.tick;
endmodule : tti_tick_gen
